// >>> debug_apb_core_decoder.sv
// shared debug apb port decoder that fans accesses out to per-core components
`timescale 1ns/100ps
// Notes on behaviour
// RULE1 - each core has debug and perf 4KB components in one 8KB slice
// RULE2 - one shared debug apb slave port reaches all cores
// RULE3 - port spans 8 to 32KB by core count, answers only when selected
// RULE4 - one core: 13 address bits, bit 12 picks area
// RULE5 - bit 12 zero is debug area, one is perf area
// RULE6 - two cores: 14 address bits, bit 13 picks the core
// RULE7 - three or four cores: 15 bits, bits 14:13 pick core
// RULE8 - master never selects bits 14:13 of 11 with three cores
// RULE9 - four cores: bits 14:13 of 11 pick core 3
// RULE10 - every core's debug interface is brought out separately
// RULE11 - no halt trigger, power-up flag or os lock init at cluster
// RULE12 - bits 11:0 pass unchanged, unselected components see nothing
module debug_apb_core_decoder #(
	parameter int NUM_CORES = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire dbg_decode_pkg::apb_req_s debug_port_req,
	output dbg_decode_pkg::apb_rsp_s debug_port_rsp,
	output dbg_decode_pkg::comp_req_s comp_req,
	output logic [dbg_decode_pkg::MAX_CORES-1:0] debug_comp_sel,
	output logic [dbg_decode_pkg::MAX_CORES-1:0] perf_comp_sel,
	input wire dbg_decode_pkg::apb_rsp_s [dbg_decode_pkg::MAX_CORES-1:0] debug_comp_rsp,
	input wire dbg_decode_pkg::apb_rsp_s [dbg_decode_pkg::MAX_CORES-1:0] perf_comp_rsp
);

	// ----------------------------------------------------------------
	// address width by configuration
	// ----------------------------------------------------------------
	// RULE4 one core width
	// RULE6 two core width
	// RULE7 three four width
	localparam int ADDR_W = (NUM_CORES <= 1) ? dbg_decode_pkg::ADDR_W_ONE :
		(NUM_CORES == 2) ? dbg_decode_pkg::ADDR_W_TWO : dbg_decode_pkg::ADDR_W_MAX;
	localparam logic [dbg_decode_pkg::ADDR_W_MAX-1:0] ADDR_MASK =
		15'((32'h1 << ADDR_W) - 32'h1);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// pick the response of the one selected component
	function automatic dbg_decode_pkg::apb_rsp_s pick_rsp(
		input logic [dbg_decode_pkg::MAX_CORES-1:0] dsel,
		input logic [dbg_decode_pkg::MAX_CORES-1:0] psel,
		input dbg_decode_pkg::apb_rsp_s [dbg_decode_pkg::MAX_CORES-1:0] drsp,
		input dbg_decode_pkg::apb_rsp_s [dbg_decode_pkg::MAX_CORES-1:0] prsp
	);
		dbg_decode_pkg::apb_rsp_s r;
		r = '0;
		for (int i = 0; i < dbg_decode_pkg::MAX_CORES; i++) begin
			if (dsel[i]) begin
				r = drsp[i];
			end
			if (psel[i]) begin
				r = prsp[i];
			end
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	// address bits above the configured width are ignored
	wire logic [dbg_decode_pkg::ADDR_W_MAX-1:0] addr_used = debug_port_req.addr & ADDR_MASK;
	wire logic [dbg_decode_pkg::MAX_CORES-1:0] dsel_now;
	wire logic [dbg_decode_pkg::MAX_CORES-1:0] psel_now;
	wire logic hole_now;

	// RULE9 four core decode
	// RULE3 select gated decode
	dbg_target_select #(
		.NUM_CORES(NUM_CORES)
	) u_select (
		.sel(debug_port_req.sel),
		.addr(addr_used),
		.debug_sel(dsel_now),
		.perf_sel(psel_now),
		.hole(hole_now)
	);

	// ----------------------------------------------------------------
	// registered access state
	// ----------------------------------------------------------------
	// one access is latched at setup and held until its answer returns
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ACCESS,
		ST_DONE
	} phase_e;

	phase_e phase_reg;
	phase_e phase_next;
	logic [dbg_decode_pkg::MAX_CORES-1:0] dsel_reg;
	logic [dbg_decode_pkg::MAX_CORES-1:0] psel_reg;
	logic hole_reg;
	dbg_decode_pkg::comp_req_s comp_reg;
	dbg_decode_pkg::apb_rsp_s rsp_reg;

	wire dbg_decode_pkg::apb_rsp_s sel_rsp = pick_rsp(dsel_reg, psel_reg,
		debug_comp_rsp, perf_comp_rsp);
	wire logic setup = debug_port_req.sel && !debug_port_req.enable;
	wire logic comp_done = (phase_reg == ST_ACCESS) && (hole_reg || sel_rsp.ready);

	// phase sequencing
	always_comb begin
		phase_next = phase_reg;
		case (phase_reg)
			ST_IDLE: begin
				if (setup) begin
					phase_next = ST_ACCESS;
				end
			end
			ST_ACCESS: begin
				if (comp_done) begin
					phase_next = ST_DONE;
				end
			end
			ST_DONE: begin
				phase_next = ST_IDLE;
			end
			default: begin
				phase_next = ST_IDLE;
			end
		endcase
	end

	// RULE2 single port state
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			phase_reg <= ST_IDLE;
		end else begin
			phase_reg <= phase_next;
		end
	end

	// RULE12 offset pass through
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dsel_reg <= dbg_decode_pkg::SEL_RESET;
			psel_reg <= dbg_decode_pkg::SEL_RESET;
			hole_reg <= 1'b0;
			comp_reg <= '0;
		end else if (phase_reg == ST_IDLE && setup) begin
			dsel_reg <= dsel_now;
			psel_reg <= psel_now;
			hole_reg <= hole_now;
			comp_reg.enable <= 1'b1;
			comp_reg.write <= debug_port_req.write;
			comp_reg.offset <= debug_port_req.addr[dbg_decode_pkg::OFFSET_W-1:0];
			comp_reg.wdata <= debug_port_req.wdata;
		end else if (comp_done) begin
			dsel_reg <= dbg_decode_pkg::SEL_RESET;
			psel_reg <= dbg_decode_pkg::SEL_RESET;
			hole_reg <= 1'b0;
			comp_reg.enable <= 1'b0;
			comp_reg.offset <= dbg_decode_pkg::OFFSET_RESET;
		end
	end

	// RULE3 answer only selected
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rsp_reg <= '0;
		end else if (comp_done) begin
			rsp_reg.ready <= 1'b1;
			rsp_reg.slverr <= hole_reg ? 1'b1 : sel_rsp.slverr;
			rsp_reg.rdata <= hole_reg ? 32'h0 : sel_rsp.rdata;
		end else begin
			rsp_reg <= '0;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// RULE1 two components per core
	// RULE10 per core ports
	// RULE11 omitted cluster pins
	assign comp_req = comp_reg;
	assign debug_comp_sel = dsel_reg;
	assign perf_comp_sel = psel_reg;
	assign debug_port_rsp = rsp_reg;

endmodule

// >>> dbg_decode_pkg.sv
// package with address layout, configuration limits and carrier structs for the debug decoder
package dbg_decode_pkg;

	// ----------------------------------------------------------------
	// address layout
	// ----------------------------------------------------------------
	localparam int MAX_CORES = 4;
	localparam int CORE_IDX_W = 2;
	localparam int OFFSET_W = 12;                  // 4KB component window
	localparam int AREA_BIT = 12;                  // area select bit
	localparam int CORE_LSB = 13;                  // lowest core select bit
	localparam int ADDR_W_ONE = 13;                // one core
	localparam int ADDR_W_TWO = 14;                // two cores
	localparam int ADDR_W_MAX = 15;                // three or four cores
	localparam int AREA_DEBUG = 0;
	localparam int AREA_PERF = 1;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [MAX_CORES-1:0] SEL_RESET = 4'h0;
	localparam logic [OFFSET_W-1:0] OFFSET_RESET = 12'h000;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	// one apb access as seen on the shared debug port
	typedef struct packed {
		logic sel;
		logic enable;
		logic write;
		logic [ADDR_W_MAX-1:0] addr;
		logic [31:0] wdata;
	} apb_req_s;

	// one apb access as routed to one core component
	typedef struct packed {
		logic enable;
		logic write;
		logic [OFFSET_W-1:0] offset;
		logic [31:0] wdata;
	} comp_req_s;

	// answer from a component or from the port
	typedef struct packed {
		logic ready;
		logic slverr;
		logic [31:0] rdata;
	} apb_rsp_s;

endpackage

// >>> dbg_target_select.sv
// combinational decode of the debug port address into a component select
`timescale 1ns/100ps
module dbg_target_select #(
	parameter int NUM_CORES = 4
) (
	input wire logic sel,
	input wire logic [dbg_decode_pkg::ADDR_W_MAX-1:0] addr,
	output logic [dbg_decode_pkg::MAX_CORES-1:0] debug_sel,
	output logic [dbg_decode_pkg::MAX_CORES-1:0] perf_sel,
	output logic hole
);

	// ----------------------------------------------------------------
	// field extraction
	// ----------------------------------------------------------------
	// upper core bits only exist in the wider configurations
	wire logic area = addr[dbg_decode_pkg::AREA_BIT];
	wire logic [1:0] core_bits = (NUM_CORES <= 1) ? 2'h0 :
		(NUM_CORES == 2) ? {1'b0, addr[dbg_decode_pkg::CORE_LSB]} :
		addr[dbg_decode_pkg::CORE_LSB +: dbg_decode_pkg::CORE_IDX_W];
	wire logic core_valid = {30'h0, core_bits} < NUM_CORES;
	wire logic [dbg_decode_pkg::MAX_CORES-1:0] core_hot =
		core_valid ? (4'h1 << core_bits) : 4'h0;

	// ----------------------------------------------------------------
	// select outputs
	// ----------------------------------------------------------------
	// RULE5 area by bit 12
	assign debug_sel = (sel && area == 1'b0) ? core_hot : 4'h0;
	assign perf_sel = (sel && area == 1'b1) ? core_hot : 4'h0;
	// RULE8 empty slot reached
	assign hole = sel && !core_valid;

endmodule

// >>> debug_apb_core_decoder_chk.sv
// checker on the ports of the debug port decoder
`timescale 1ns/100ps
module debug_apb_core_decoder_chk #(
	parameter int NUM_CORES = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire dbg_decode_pkg::apb_req_s debug_port_req,
	input wire dbg_decode_pkg::apb_rsp_s debug_port_rsp,
	input wire dbg_decode_pkg::comp_req_s comp_req,
	input wire logic [3:0] debug_comp_sel,
	input wire logic [3:0] perf_comp_sel,
	input wire dbg_decode_pkg::apb_rsp_s [3:0] debug_comp_rsp,
	input wire dbg_decode_pkg::apb_rsp_s [3:0] perf_comp_rsp
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// selected target and its read word
	wire logic [3:0] any_sel = debug_comp_sel | perf_comp_sel;
	wire logic [1:0] core_idx = NUM_CORES == 1 ? 2'h0 : NUM_CORES == 2 ?
		{1'b0, debug_port_req.addr[13]} : debug_port_req.addr[14:13];
	logic [31:0] routed;
	always_comb begin
		routed = 32'h0;
		for (int i = 0; i < 4; i++)
			if (any_sel[i])
				routed = debug_comp_sel[i] ? debug_comp_rsp[i].rdata : perf_comp_rsp[i].rdata;
	end
	one_target_a: assert property ($onehot0(any_sel)) else $error("two targets");
	select_gate_a: assert property ($rose(|any_sel) |-> $past(debug_port_req.sel))
		else $error("target without select");
	area_pick_a: assert property ($rose(|any_sel) |->
		(|perf_comp_sel) == $past(debug_port_req.addr[12])) else $error("wrong area");
	core_pick_a: assert property ($rose(|any_sel) |->
		any_sel == 4'h1 << $past(core_idx)) else $error("wrong core");
	offset_pass_a: assert property (comp_req.enable |->
		comp_req.offset == debug_port_req.addr[11:0] && comp_req.write == debug_port_req.write)
		else $error("offset altered");
	wdata_pass_a: assert property (comp_req.enable |->
		comp_req.wdata == debug_port_req.wdata) else $error("write data altered");
	quiet_idle_a: assert property (!comp_req.enable |-> any_sel == 4'h0)
		else $error("select without access");
	answer_bound_a: assert property ($rose(comp_req.enable) |-> ##[1:20] debug_port_rsp.ready)
		else $error("no answer");
	single_pulse_a: assert property (debug_port_rsp.ready |=> !debug_port_rsp.ready)
		else $error("ready too long");
	data_route_a: assert property (debug_port_rsp.ready |-> debug_port_rsp.rdata == $past(routed))
		else $error("wrong read data");
endmodule
bind debug_apb_core_decoder debug_apb_core_decoder_chk #(.NUM_CORES(NUM_CORES)) u_chk (.clk(clk),
	.rst_n(rst_n), .debug_port_req(debug_port_req), .debug_port_rsp(debug_port_rsp),
	.comp_req(comp_req), .debug_comp_sel(debug_comp_sel), .perf_comp_sel(perf_comp_sel),
	.debug_comp_rsp(debug_comp_rsp), .perf_comp_rsp(perf_comp_rsp));

// >>> dbg_apb_master.sv
// bus master model of the external debug system
`timescale 1ns/100ps
module dbg_apb_master #(
	parameter int NUM_CORES = 4
) (
	input wire logic clk,
	output dbg_decode_pkg::apb_req_s req,
	input wire dbg_decode_pkg::apb_rsp_s rsp
);
	logic [31:0] rdata;
	logic err;
	logic ok;
	initial req = '{1'b0, 1'b0, 1'b0, 15'h7fff, 32'h0};
	// one access: setup, enable, hold until ready
	task automatic access(input logic w, input logic [14:0] a, input logic [31:0] d);
		int n;
		n = 0;
		ok = 1'b0;
		if (NUM_CORES == 3 && a[14:13] == 2'h3)
			return;
		@(negedge clk);
		req = '{1'b1, 1'b0, w, a, d};
		@(negedge clk);
		req.enable = 1'b1;
		// wait for the ready pulse, giving up after 40 cycles
		do begin
			@(negedge clk);
			n++;
		end while (rsp.ready !== 1'b1 && n < 40);
		rdata = rsp.rdata;
		err = rsp.slverr;
		ok = rsp.ready === 1'b1;
		@(negedge clk);
		// released lines show the inverse
		req = '{1'b0, 1'b0, ~w, ~a, ~d};
	endtask
endmodule

// >>> debug_apb_core_decoder_bench.sv
// bench for the debug port decoder with core components
`timescale 1ns/100ps
module debug_apb_core_decoder_bench;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	int miscompares = 0;
	int checks = 0;
	int stall = 0;
	int wait_cnt = 0;
	logic [31:0] seen_wdata = 32'h0;
	logic seen_write = 1'b0;
	dbg_decode_pkg::apb_req_s req;
	dbg_decode_pkg::apb_rsp_s rsp;
	dbg_decode_pkg::comp_req_s comp_req;
	logic [3:0] dsel;
	logic [3:0] psel;
	dbg_decode_pkg::apb_rsp_s [3:0] drsp = '0;
	dbg_decode_pkg::apb_rsp_s [3:0] prsp = '0;
	always #20 clk = ~clk;
	dbg_apb_master u_dbg_apb_master (.clk(clk), .req(req), .rsp(rsp));
	debug_apb_core_decoder u_debug_apb_core_decoder (.clk(clk), .rst_n(rst_n),
		.debug_port_req(req), .debug_port_rsp(rsp), .comp_req(comp_req), .debug_comp_sel(dsel),
		.perf_comp_sel(psel), .debug_comp_rsp(drsp), .perf_comp_rsp(prsp));
	function automatic logic [31:0] pat(input logic a, input logic [1:0] c, input logic [11:0] o);
		return {a ? 4'hf : 4'hd, 10'h0, c, 4'h0, o};
	endfunction
	// components answer after stall cycles, idle ones show their pattern data without ready
	always @(negedge clk) begin
		wait_cnt = (dsel | psel) != 4'h0 ? wait_cnt + 1 : 0;
		if ((dsel | psel) != 4'h0) begin
			seen_wdata = comp_req.wdata;
			seen_write = comp_req.write;
		end
		for (int i = 0; i < 4; i++) begin
			drsp[i] = '{dsel[i] && wait_cnt > stall, 1'b0, pat(1'b0, i[1:0], comp_req.offset)};
			prsp[i] = '{psel[i] && wait_cnt > stall, i == 2, pat(1'b1, i[1:0], comp_req.offset)};
		end
	end
	// smaller configurations share the request, their components answer at once
	for (genvar g = 1; g < 4; g++) begin : g_cfg
		dbg_decode_pkg::apb_req_s sreq;
		dbg_decode_pkg::apb_rsp_s srsp;
		dbg_decode_pkg::comp_req_s scomp;
		logic [3:0] sd;
		logic [3:0] sp;
		dbg_decode_pkg::apb_rsp_s [3:0] sdr = '0;
		dbg_decode_pkg::apb_rsp_s [3:0] spr = '0;
		logic [31:0] got = 32'h0;
		int hits = 0;
		// three core port never sees slot 3 selected
		always_comb begin
			sreq = req;
			sreq.sel = req.sel && !(g == 3 && req.addr[14:13] == 2'h3);
		end
		debug_apb_core_decoder #(.NUM_CORES(g)) u_debug_apb_core_decoder (.clk(clk),
			.rst_n(rst_n), .debug_port_req(sreq), .debug_port_rsp(srsp), .comp_req(scomp),
			.debug_comp_sel(sd), .perf_comp_sel(sp), .debug_comp_rsp(sdr),
			.perf_comp_rsp(spr));
		// component answers and capture of the returned word
		always @(negedge clk) begin
			for (int i = 0; i < 4; i++) begin
				sdr[i] = '{sd[i], 1'b0, pat(1'b0, i[1:0], scomp.offset)};
				spr[i] = '{sp[i], 1'b0, pat(1'b1, i[1:0], scomp.offset)};
			end
			if (srsp.ready === 1'b1) begin
				got = srsp.rdata;
				hits++;
			end
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic acc(input logic w, input logic [1:0] c, input logic a, input logic [11:0] o);
		int h1;
		int h2;
		int h3;
		h1 = g_cfg[1].hits;
		h2 = g_cfg[2].hits;
		h3 = g_cfg[3].hits;
		u_dbg_apb_master.access(w, {c, a, o}, {20'h5a5a5, o});
		check(u_dbg_apb_master.ok, 1'b1);
		check(u_dbg_apb_master.rdata, pat(a, c, o));
		check(u_dbg_apb_master.err, c == 2'h2 && a);
		check(seen_write, w);
		check(seen_wdata, {20'h5a5a5, o});
		check(g_cfg[1].got, pat(a, 2'h0, o));
		check(g_cfg[1].hits - h1, 32'h1);
		check(g_cfg[2].got, pat(a, {1'b0, c[0]}, o));
		check(g_cfg[2].hits - h2, 32'h1);
		check(g_cfg[3].hits - h3, {31'h0, c != 2'h3});
		if (c != 2'h3)
			check(g_cfg[3].got, pat(a, c, o));
	endtask
	task automatic t_nosel();
		repeat (6) begin
			@(negedge clk);
			check(dsel | psel, 4'h0);
			check(rsp.ready, 1'b0);
		end
	endtask
	task automatic t_map();
		for (int k = 0; k < 16; k++)
			acc(k[0], k[2:1], k[3], k[0] ? 12'hfff : 12'h000);
	endtask
	task automatic t_stall();
		stall = 3;
		acc(1'b0, 2'h3, 1'b1, 12'h7c4);
		stall = 0;
	endtask
	task automatic conclude();
		if (miscompares == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		t_nosel();
		t_map();
		t_stall();
		conclude();
	end
	// watchdog
	initial begin
		#200000;
		miscompares++;
		conclude();
	end
endmodule
